// file: tcr_pkg.sv
package tcr_pkg;
   localparam int         NCH           = 12;
   localparam logic [7:0] A_SYS_CTRL    = 8'h09;
   localparam logic [7:0] A_REF_LO      = 8'h0a;
   localparam logic [7:0] A_REF_HI      = 8'h0b;
   localparam logic [7:0] A_HOLD_LO     = 8'h0c;
   localparam logic [7:0] A_HOLD_HI     = 8'h0d;
   localparam logic [7:0] A_RES_A       = 8'h10;
   localparam logic [7:0] A_RES_B       = 8'h11;
   localparam logic [7:0] A_RES_C       = 8'h12;
   localparam logic [7:0] A_LVL_LO      = 8'h13;
   localparam logic [7:0] A_LVL_HI      = 8'h14;
   localparam logic [7:0] A_MARK        = 8'h15;
   localparam logic [7:0] RST_ZERO      = 8'h00;
   localparam logic [7:0] RST_LVL_HI    = 8'hf0;
   localparam logic [7:0] HI_MASK       = 8'h0f;
   localparam logic [7:0] PTR_STEP      = 8'h01;
   localparam int         SOFT_RST_BIT  = 3;
   localparam int         LED_B_BIT     = 7;
   localparam int         LED_A_BIT     = 6;
   localparam int         AUX_B_BIT     = 5;
   localparam int         AUX_A_BIT     = 4;
   localparam logic [1:0] CODE_IDLE     = 2'h0;
   localparam logic [1:0] CODE_TOUCH    = 2'h3;
   localparam logic [3:0] CNT_ZERO      = 4'h0;
   localparam logic [3:0] CNT_ONE       = 4'h1;
   localparam logic [3:0] CNT_FULL      = 4'h8;
   localparam logic [3:0] CNT_STEP      = 4'h1;
   // Serial address, value arbitrary
   localparam logic [6:0] DEV_ADDR_DFLT = 7'h2a;

   typedef enum logic [2:0] {
      BS_IDLE,
      BS_ADDR,
      BS_ADDR_ACK,
      BS_WR_BYTE,
      BS_WR_ACK,
      BS_RD_BYTE,
      BS_RD_ACK
   } tcr_bus_st_t;
endpackage

// file: tcr_chan.sv
`timescale 1ns/100ps
module tcr_chan
   import tcr_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       soft_rst_i,
   // Channel control
   input  wire logic       hold_i,
   input  wire logic       level_i,
   input  wire logic       touch_i,
   // Channel outputs
   output logic            pin_o,
   output logic            pin_oe_o,
   output logic            sense_en_o,
   output logic [1:0]      code_o
);
   typedef struct packed {
      logic       pin;
      logic       oe;
      logic       sense;
      logic [1:0] code;
   } tcr_chan_t;

   localparam tcr_chan_t C_RST = '{
      pin:   1'b0,
      oe:    1'b0,
      sense: 1'b1,
      code:  CODE_IDLE
   };

   tcr_chan_t s;
   tcr_chan_t next_s;

   always_comb
   begin
      next_s = s;
      next_s.sense = ~hold_i;
      next_s.oe    = hold_i;
      next_s.pin   = hold_i & level_i;
      next_s.code  = (touch_i && !hold_i) ? CODE_TOUCH : CODE_IDLE;
      if (soft_rst_i)
      begin
         next_s = C_RST;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         s <= C_RST;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign pin_o      = s.pin;
   assign pin_oe_o   = s.oe;
   assign sense_en_o = s.sense;
   assign code_o     = s.code;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   chk_held_pin_drive: assert property (
      hold_i && !soft_rst_i |=> pin_oe_o && pin_o == $past(level_i))
      else $error("held pin not driven at its level");
   chk_sensing_no_drive: assert property (
      !hold_i |=> !pin_oe_o && !pin_o && sense_en_o)
      else $error("sensing pin is driven");
   chk_code_legal: assert property (
      code_o == CODE_IDLE || code_o == CODE_TOUCH)
      else $error("reserved result code produced");
   chk_hold_release: assert property (
      $fell(hold_i) |=> !pin_oe_o ##1 !pin_oe_o || $past(hold_i))
      else $error("pin still driven after release");
endmodule

// file: tcr_regs.sv
`timescale 1ns/100ps
module tcr_regs
   import tcr_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DFLT
)
(
   // Clock and reset
   input  wire logic            clk_i,
   input  wire logic            reset_n_i,
   // Two-wire serial port
   input  wire logic            scl_i,
   input  wire logic            sda_i,
   output logic                 sda_o,
   output logic                 sda_oe_o,
   // Analog front end
   input  wire logic [NCH-1:0]  touch_i,
   output logic [NCH-1:0]       ref_reset_o,
   output logic [NCH-1:0]       sense_en_o,
   // Channel pins
   output logic [NCH-1:0]       ch_pin_o,
   output logic [NCH-1:0]       ch_pin_oe_o,
   // Extra output pins
   output logic                 led_pin_a_o,
   output logic                 led_pin_b_o,
   output logic                 aux_pin_a_o,
   output logic                 aux_pin_b_o
);
   typedef struct packed {
      tcr_bus_st_t st;
      logic        scl_q;
      logic        sda_q;
      logic [3:0]  cnt;
      logic [7:0]  sh;
      logic [7:0]  ptr;
      logic        have_ptr;
      logic        rw;
      logic        sda_oe;
      logic        sda_out;
      logic        soft_rst;
      logic [7:0]  ref_lo;
      logic [7:0]  ref_hi;
      logic [7:0]  hold_lo;
      logic [7:0]  hold_hi;
      logic [7:0]  lvl_lo;
      logic [7:0]  lvl_hi;
      logic [7:0]  mark;
   } tcr_regs_t;

   localparam tcr_regs_t S_RST = '{
      st:       BS_IDLE,
      scl_q:    1'b1,
      sda_q:    1'b1,
      cnt:      CNT_ZERO,
      sh:       RST_ZERO,
      ptr:      RST_ZERO,
      have_ptr: 1'b0,
      rw:       1'b0,
      sda_oe:   1'b0,
      sda_out:  1'b0,
      soft_rst: 1'b0,
      ref_lo:   RST_ZERO,
      ref_hi:   RST_ZERO,
      hold_lo:  RST_ZERO,
      hold_hi:  RST_ZERO,
      lvl_lo:   RST_ZERO,
      lvl_hi:   RST_LVL_HI,
      mark:     RST_ZERO
   };

   tcr_regs_t          s;
   tcr_regs_t          next_s;
   logic               rise;
   logic               fall;
   logic               start;
   logic               stop;
   logic               wr;
   logic [7:0]         rdat;
   logic [2*NCH-1:0]   res;
   logic [NCH-1:0]     hold;
   logic [NCH-1:0]     level;

   assign hold  = {s.hold_hi[3:0], s.hold_lo};
   assign level = {s.lvl_hi[3:0], s.lvl_lo};

   // Per-channel sensing and pin drive
   for (genvar g = 0; g < NCH; g++)
   begin : gen_ch
      tcr_chan u_ch (
         .clk_i      (clk_i),
         .reset_n_i  (reset_n_i),
         .soft_rst_i (s.soft_rst),
         .hold_i     (hold[g]),
         .level_i    (level[g]),
         .touch_i    (touch_i[g]),
         .pin_o      (ch_pin_o[g]),
         .pin_oe_o   (ch_pin_oe_o[g]),
         .sense_en_o (sense_en_o[g]),
         .code_o     (res[2*g+1:2*g])
      );
   end

   // Register read mux
   always_comb
   begin
      rdat = RST_ZERO;
      if (s.ptr == A_REF_LO)
      begin
         rdat = s.ref_lo;
      end
      else if (s.ptr == A_REF_HI)
      begin
         rdat = s.ref_hi;
      end
      else if (s.ptr == A_HOLD_LO)
      begin
         rdat = s.hold_lo;
      end
      else if (s.ptr == A_HOLD_HI)
      begin
         rdat = s.hold_hi;
      end
      else if (s.ptr == A_RES_A)
      begin
         rdat = res[7:0];
      end
      else if (s.ptr == A_RES_B)
      begin
         rdat = res[15:8];
      end
      else if (s.ptr == A_RES_C)
      begin
         rdat = res[23:16];
      end
      else if (s.ptr == A_LVL_LO)
      begin
         rdat = s.lvl_lo;
      end
      else if (s.ptr == A_LVL_HI)
      begin
         rdat = s.lvl_hi;
      end
      else if (s.ptr == A_MARK)
      begin
         rdat = s.mark;
      end
   end

   always_comb
   begin
      next_s       = s;
      next_s.scl_q = scl_i;
      next_s.sda_q = sda_i;
      next_s.soft_rst = 1'b0;
      rise  = scl_i & ~s.scl_q;
      fall  = ~scl_i & s.scl_q;
      start = scl_i & s.scl_q & s.sda_q & ~sda_i;
      stop  = scl_i & s.scl_q & ~s.sda_q & sda_i;
      wr    = 1'b0;
      if (start)
      begin
         next_s.st       = BS_ADDR;
         next_s.cnt      = CNT_ZERO;
         next_s.have_ptr = 1'b0;
         next_s.sda_oe   = 1'b0;
      end
      else if (stop)
      begin
         next_s.st     = BS_IDLE;
         next_s.sda_oe = 1'b0;
      end
      else
      begin
         case (s.st)
            BS_ADDR, BS_WR_BYTE:
            begin
               if (rise && s.cnt != CNT_FULL)
               begin
                  next_s.sh  = {s.sh[6:0], sda_i};
                  next_s.cnt = s.cnt + CNT_STEP;
               end
               else if (fall && s.cnt == CNT_FULL)
               begin
                  next_s.cnt = CNT_ZERO;
                  if (s.st == BS_ADDR)
                  begin
                     if (s.sh[7:1] == DEV_ADDR)
                     begin
                        next_s.rw     = s.sh[0];
                        next_s.sda_oe = 1'b1;
                        next_s.st     = BS_ADDR_ACK;
                     end
                     else
                     begin
                        next_s.st = BS_IDLE;
                     end
                  end
                  else
                  begin
                     next_s.sda_oe = 1'b1;
                     next_s.st     = BS_WR_ACK;
                     if (!s.have_ptr)
                     begin
                        next_s.ptr      = s.sh;
                        next_s.have_ptr = 1'b1;
                     end
                     else
                     begin
                        wr         = 1'b1;
                        next_s.ptr = s.ptr + PTR_STEP;
                     end
                  end
               end
            end
            BS_ADDR_ACK, BS_RD_ACK:
            begin
               // Host NACK ends the read
               if (rise && s.st == BS_RD_ACK && sda_i)
               begin
                  next_s.st = BS_IDLE;
               end
               else if (fall && s.rw)
               begin
                  next_s.sh     = rdat;
                  next_s.sda_oe = ~rdat[7];
                  next_s.cnt    = CNT_ONE;
                  next_s.ptr    = s.ptr + PTR_STEP;
                  next_s.st     = BS_RD_BYTE;
               end
               else if (fall)
               begin
                  next_s.sda_oe = 1'b0;
                  next_s.st     = BS_WR_BYTE;
               end
            end
            BS_WR_ACK:
            begin
               if (fall)
               begin
                  next_s.sda_oe = 1'b0;
                  next_s.st     = BS_WR_BYTE;
               end
            end
            BS_RD_BYTE:
            begin
               if (fall && s.cnt == CNT_FULL)
               begin
                  next_s.sda_oe = 1'b0;
                  next_s.st     = BS_RD_ACK;
               end
               else if (fall)
               begin
                  next_s.sh     = {s.sh[6:0], 1'b0};
                  next_s.sda_oe = ~s.sh[6];
                  next_s.cnt    = s.cnt + CNT_STEP;
               end
            end
            default:
            begin
               next_s.st = BS_IDLE;
            end
         endcase
      end

      if (wr)
      begin
         if (s.ptr == A_REF_LO)
         begin
            next_s.ref_lo = s.sh;
         end
         else if (s.ptr == A_REF_HI)
         begin
            next_s.ref_hi = s.sh & HI_MASK;
         end
         else if (s.ptr == A_HOLD_LO)
         begin
            next_s.hold_lo = s.sh;
         end
         else if (s.ptr == A_HOLD_HI)
         begin
            next_s.hold_hi = s.sh & HI_MASK;
         end
         else if (s.ptr == A_LVL_LO)
         begin
            next_s.lvl_lo = s.sh;
         end
         else if (s.ptr == A_LVL_HI)
         begin
            next_s.lvl_hi = s.sh;
         end
         else if (s.ptr == A_MARK)
         begin
            next_s.mark = s.sh;
         end
         else if (s.ptr == A_SYS_CTRL)
         begin
            next_s.soft_rst = s.sh[SOFT_RST_BIT];
         end
      end

      if (s.soft_rst)
      begin
         next_s = S_RST;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         s <= S_RST;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign ref_reset_o = {s.ref_hi[3:0], s.ref_lo};
   assign sda_o       = s.sda_out;
   assign sda_oe_o    = s.sda_oe;
   assign led_pin_b_o = s.lvl_hi[LED_B_BIT];
   assign led_pin_a_o = s.lvl_hi[LED_A_BIT];
   assign aux_pin_b_o = s.lvl_hi[AUX_B_BIT];
   assign aux_pin_a_o = s.lvl_hi[AUX_A_BIT];

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   chk_ref_lo_write: assert property (
      wr && s.ptr == A_REF_LO && !s.soft_rst
      |=> ref_reset_o[7:0] == $past(s.sh))
      else $error("baseline renew bits not written");
   chk_reserved_zero: assert property (
      s.ref_hi[7:4] == 4'h0 && s.hold_hi[7:4] == 4'h0)
      else $error("reserved bits not zero");
   chk_hold_hi_write: assert property (
      wr && s.ptr == A_HOLD_HI && !s.soft_rst
      |=> s.hold_hi == ($past(s.sh) & HI_MASK))
      else $error("upper hold write wrong");
   chk_marker_write: assert property (
      wr && s.ptr == A_MARK && !s.soft_rst |=> s.mark == $past(s.sh))
      else $error("marker write lost");
   chk_soft_reset: assert property (
      s.soft_rst |=> s.st == BS_IDLE && s.mark == RST_ZERO
      && s.hold_lo == RST_ZERO && s.lvl_hi == RST_LVL_HI ##1 !sda_oe_o)
      else $error("soft reset did not restore defaults");
   chk_ref_sticky: assert property (
      !wr && !s.soft_rst |=> $stable(ref_reset_o))
      else $error("baseline renew bits changed on their own");
endmodule

// file: tcr_host_model.sv
`timescale 1ns/100ps
module tcr_host_model
   import tcr_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DFLT
)
(
   // Clock and resolved data wire
   input  wire logic clk_i,
   input  wire logic sda_i,
   // Host drive, data pulled low while enable high
   output logic      scl_o,
   output logic      sda_oe_o
);
   initial
   begin
      scl_o    = 1'b1;
      sda_oe_o = 1'b0;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // Also serves as repeated start from a low clock
   task automatic start_c();
      sda_oe_o <= 1'b0;
      cyc(2);
      scl_o <= 1'b1;
      cyc(4);
      sda_oe_o <= 1'b1;
      cyc(4);
      scl_o <= 1'b0;
      cyc(2);
   endtask

   task automatic stop_c();
      sda_oe_o <= 1'b1;
      cyc(2);
      scl_o <= 1'b1;
      cyc(4);
      sda_oe_o <= 1'b0;
      cyc(4);
   endtask

   task automatic send_byte(input logic [7:0] b, output logic nak);
      for (int i = 7; i >= 0; i--)
      begin
         sda_oe_o <= ~b[i];
         cyc(2);
         scl_o <= 1'b1;
         cyc(4);
         scl_o <= 1'b0;
         cyc(2);
      end
      sda_oe_o <= 1'b0;
      cyc(2);
      scl_o <= 1'b1;
      cyc(2);
      nak = sda_i;
      cyc(2);
      scl_o <= 1'b0;
      cyc(2);
   endtask

   task automatic recv_byte(input logic nak, output logic [7:0] b);
      sda_oe_o <= 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         cyc(2);
         scl_o <= 1'b1;
         cyc(2);
         b[i] = sda_i;
         cyc(2);
         scl_o <= 1'b0;
      end
      cyc(2);
      sda_oe_o <= ~nak;
      cyc(2);
      scl_o <= 1'b1;
      cyc(4);
      scl_o <= 1'b0;
      cyc(2);
   endtask

   task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                            input logic [7:0] d, output logic nak);
      logic n1;
      logic n2;
      logic n3;
      start_c();
      send_byte({dev, 1'b0}, n1);
      send_byte(ptr, n2);
      send_byte(d, n3);
      stop_c();
      nak = n1 | n2 | n3;
   endtask

   task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d);
      logic n;
      start_c();
      send_byte({DEV_ADDR, 1'b0}, n);
      send_byte(ptr, n);
      start_c();
      send_byte({DEV_ADDR, 1'b1}, n);
      recv_byte(1'b1, d);
      stop_c();
   endtask
endmodule

// file: tb_top.sv
`timescale 1ns/100ps
module tb_top
   import tcr_pkg::*;
;
   logic           clk_i = 1'b0;
   logic           reset_n_i;
   logic [NCH-1:0] touch_i;
   logic           scl;
   logic           host_oe;
   logic           dev_sda;
   logic           dev_oe;
   logic           sda;
   logic [NCH-1:0] ref_rst;
   logic [NCH-1:0] sense;
   logic [NCH-1:0] pin;
   logic [NCH-1:0] pin_oe;
   logic [3:0]     xpin;
   int             err_count = 0;
   int             samples_checked = 0;

   always #10 clk_i = ~clk_i;
   // Pull-up wire
   assign sda = !(host_oe || (dev_oe && !dev_sda));

   tcr_regs i_tcr_regs (
      .clk_i       (clk_i),
      .reset_n_i   (reset_n_i),
      .scl_i       (scl),
      .sda_i       (sda),
      .sda_o       (dev_sda),
      .sda_oe_o    (dev_oe),
      .touch_i     (touch_i),
      .ref_reset_o (ref_rst),
      .sense_en_o  (sense),
      .ch_pin_o    (pin),
      .ch_pin_oe_o (pin_oe),
      .led_pin_a_o (xpin[2]),
      .led_pin_b_o (xpin[3]),
      .aux_pin_a_o (xpin[0]),
      .aux_pin_b_o (xpin[1])
   );

   tcr_host_model i_tcr_host_model (
      .clk_i    (clk_i),
      .sda_i    (sda),
      .scl_o    (scl),
      .sda_oe_o (host_oe)
   );

   task automatic give_verdict();
      if (err_count == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic cmp8(input string nm, input logic [7:0] e, g);
      samples_checked++;
      if (g !== e)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cmp12(input string nm, input logic [11:0] e, g);
      samples_checked++;
      if (g !== e)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rd(input logic [7:0] a, e);
      logic [7:0] d;
      i_tcr_host_model.read_reg(a, d);
      cmp8($sformatf("reg %h", a), e, d);
   endtask

   task automatic wr(input logic [7:0] a, d, input logic enak = 1'b0);
      logic n;
      i_tcr_host_model.write_reg(DEV_ADDR_DFLT, a, d, n);
      cmp8("ack", {7'h00, enak}, {7'h00, n});
   endtask

   function automatic logic [7:0] res(input logic [11:0] t, h, input int n);
      for (int k = 0; k < 4; k++)
         res[2*k +: 2] = (t[4*n+k] && !h[4*n+k]) ? CODE_TOUCH : CODE_IDLE;
   endfunction

   task automatic t_defaults();
      rd(A_REF_LO, 8'h00);
      rd(A_REF_HI, 8'h00);
      rd(A_HOLD_LO, 8'h00);
      rd(A_HOLD_HI, 8'h00);
      rd(A_LVL_LO, 8'h00);
      rd(A_LVL_HI, 8'hf0);
      rd(A_MARK, 8'h00);
      rd(A_RES_C, 8'h00);
      cmp8("xpins", 8'h0f, {4'h0, xpin});
      cmp12("sense", 12'hfff, sense);
      cmp12("pin oe", 12'h000, pin_oe);
      cmp12("ref", 12'h000, ref_rst);
   endtask

   task automatic t_ref_reset();
      wr(A_REF_LO, 8'h5a);
      wr(A_REF_HI, 8'hff);
      rd(A_REF_HI, 8'h0f);
      cmp12("ref", 12'hf5a, ref_rst);
      wr(A_REF_LO, 8'h00);
      cmp12("ref", 12'hf00, ref_rst);
      wr(A_REF_HI, 8'h00);
   endtask

   task automatic t_hold_pins();
      wr(A_LVL_LO, 8'ha5);
      wr(A_LVL_HI, 8'h3c);
      cmp8("xpins", 8'h03, {4'h0, xpin});
      cmp12("pin oe", 12'h000, pin_oe);
      wr(A_HOLD_LO, 8'h24);
      wr(A_HOLD_HI, 8'hff);
      rd(A_HOLD_HI, 8'h0f);
      cmp12("pin oe", 12'hf24, pin_oe);
      cmp12("pin", 12'hc24, pin);
      cmp12("sense", 12'h0db, sense);
      wr(A_HOLD_LO, 8'h00);
      cmp12("pin oe", 12'hf00, pin_oe);
      cmp12("sense", 12'h0ff, sense);
      wr(A_HOLD_HI, 8'h00);
      cmp12("pin oe", 12'h000, pin_oe);
   endtask

   task automatic t_results();
      touch_i <= 12'ha69;
      repeat (2) @(posedge clk_i);
      rd(A_RES_A, res(12'ha69, 12'h000, 0));
      rd(A_RES_B, res(12'ha69, 12'h000, 1));
      rd(A_RES_C, res(12'ha69, 12'h000, 2));
      wr(A_RES_A, 8'h00);
      rd(A_RES_A, res(12'ha69, 12'h000, 0));
      wr(A_HOLD_LO, 8'h08);
      rd(A_RES_A, res(12'ha69, 12'h008, 0));
      wr(A_HOLD_LO, 8'h00);
      touch_i <= 12'h000;
      rd(A_RES_B, 8'h00);
   endtask

   task automatic t_marker_soft_reset_bit();
      wr(A_MARK, 8'ha5);
      rd(A_MARK, 8'ha5);
      wr(A_LVL_HI, 8'h0f);
      wr(A_REF_LO, 8'h11);
      wr(A_SYS_CTRL, 8'h08, 1'b1);
      t_defaults();
   endtask

   task automatic t_refused();
      logic n;
      i_tcr_host_model.write_reg(DEV_ADDR_DFLT ^ 7'h01, A_MARK, 8'h3c, n);
      cmp8("wrong addr", 8'h01, {7'h00, n});
      rd(A_MARK, 8'h00);
      rd(8'h30, 8'h00);
   endtask

   task automatic t_burst();
      logic       n;
      logic [7:0] d;
      i_tcr_host_model.start_c();
      i_tcr_host_model.send_byte({DEV_ADDR_DFLT, 1'b0}, n);
      i_tcr_host_model.send_byte(A_LVL_HI, n);
      i_tcr_host_model.send_byte(8'h5a, n);
      i_tcr_host_model.send_byte(8'h3c, n);
      i_tcr_host_model.stop_c();
      i_tcr_host_model.start_c();
      i_tcr_host_model.send_byte({DEV_ADDR_DFLT, 1'b0}, n);
      i_tcr_host_model.send_byte(A_LVL_HI, n);
      i_tcr_host_model.start_c();
      i_tcr_host_model.send_byte({DEV_ADDR_DFLT, 1'b1}, n);
      i_tcr_host_model.recv_byte(1'b0, d);
      cmp8("burst lvl hi", 8'h5a, d);
      i_tcr_host_model.recv_byte(1'b1, d);
      cmp8("burst marker", 8'h3c, d);
      i_tcr_host_model.stop_c();
      cmp8("xpins", 8'h05, {4'h0, xpin});
   endtask

   task automatic t_hard_reset();
      wr(A_MARK, 8'h5a);
      wr(A_LVL_HI, 8'h00);
      reset_n_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      t_defaults();
   endtask

   initial
   begin
      repeat (60000) @(posedge clk_i);
      err_count++;
      give_verdict();
   end

   initial
   begin
      reset_n_i = 1'b0;
      touch_i   = 12'h000;
      repeat (8) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      t_defaults();
      t_ref_reset();
      t_hold_pins();
      t_results();
      t_burst();
      t_marker_soft_reset_bit();
      t_refused();
      t_hard_reset();
      give_verdict();
   end
endmodule
